// ===== shared/sid_map.vh
/*
 * register map, field positions, reset values and timing counts of the
 * step input decoder. assumes a 40 MHz system clock and AXI4-Lite access.
 */
`ifndef SID_MAP_VH
`define SID_MAP_VH

// register byte offsets
`define SID_CTRL_ADDR      4'h0
`define SID_FILT_ADDR      4'h4
`define SID_CURR_ADDR      4'h8
`define SID_POS_ADDR       4'hc

// ctrl fields
`define SID_CTRL_MODE_LSB  0
`define SID_CTRL_MODE_MSB  1
`define SID_CTRL_INV_BIT   2
`define SID_CTRL_RES_LSB   8
`define SID_CTRL_RES_MSB   16
`define SID_CTRL_RESET     32'h0001_0000

// clock input modes
`define SID_MODE_STEPDIR   2'h0
`define SID_MODE_QUAD      2'h1
`define SID_MODE_UPDN      2'h2

// glitch filter: least pulse 50 ns, longest 12.9 us, at 25 ns per cycle
`define SID_CLK_PERIOD_NS  25
`define SID_FILT_MIN_NS    50
`define SID_FILT_MAX_NS    12900
`define SID_FILT_MIN_CYC   ((`SID_FILT_MIN_NS + `SID_CLK_PERIOD_NS - 1) / `SID_CLK_PERIOD_NS)
`define SID_FILT_MAX_CYC   (`SID_FILT_MAX_NS / `SID_CLK_PERIOD_NS)
`define SID_FILT_RESET     32'h0000_0002

// run and hold current reset values, percent
`define SID_CURR_RUN_RESET 8'h19
`define SID_CURR_HLD_RESET 8'h05

`define SID_RESP_OKAY      2'h0
`define SID_RESP_SLVERR    2'h2

`endif

// ===== rtl/sid_step_input_decoder.v
/*
 * step input decoder: glitch filters the step/channel-a/up, direction/
 * channel-b/down and enable inputs, decodes them by the selected clock
 * mode into a microstep position count, and gates the power stage.
 * assumes inputs are already synchronous to clk_sys_in and an AXI4-Lite
 * master that keeps at most one write and one read under way.
 */
// Decided for this implementation: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "sid_map.vh"

// Behaviour
// - three inputs: step/phase a/up, direction/phase b/down, enable.
// - software selects step/direction, quadrature or up/down decoding.
// - after reset decoding is step/direction.
// - enable high keeps power stage on.
// - enable low switches power stage off.
// - position keeps counting whatever the enable state.
// - step/direction: each step rising edge moves one microstep, sign from direction.
// - each move is scaled by the active microstep resolution.
// - direction and resolution latched at each step rising edge.
// - direction or resolution change acts only at the following step edge.
// - run and hold current settings apply at once.
// - glitch filter minimum width selectable from 50 ns to 12.9 us.
// - software chooses which direction level means clockwise.
// - quadrature mode tracks another controller's encoder-style output.
module sid_step_input_decoder (
   // clock and reset
   input  wire        clk_sys_in,
   input  wire        nrst_in,
   // isolated logic inputs
   input  wire        step_in,
   input  wire        dir_in,
   input  wire        enable_in,
   // power stage and position generator
   output reg         power_en_out,
   output reg  [31:0] position_out,
   output reg  [7:0]  run_current_out,
   output reg  [7:0]  hold_current_out,
   // axi4-lite write address and data
   input  wire [3:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   // axi4-lite read
   input  wire [3:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready
);

   reg  [31:0] ctrl;
   reg  [31:0] filt;
   reg  [3:0]  aw_addr;
   reg         aw_held;
   reg  [31:0] w_data;
   reg  [3:0]  w_strb;
   reg         w_held;
   // filtered inputs and their run counters
   reg  [2:0]  filt_q;
   reg  [9:0]  filt_cnt [0:2];
   reg  [2:0]  filt_prev;
   // values latched at the step edge
   reg         lat_dir;
   reg  [8:0]  lat_res;
   wire [1:0]  mode;
   wire [2:0]  raw;
   wire [9:0]  filt_limit;
   wire        a_rise;
   wire        b_rise;
   wire        a_chg;
   wire        b_chg;
   wire        dir_eff;
   wire [31:0] res_ext;
   reg  [31:0] next_position;
   reg         next_lat_dir;
   reg  [8:0]  next_lat_res;
   reg  [31:0] wr_merged;
   integer     i;
   integer     j;

   // filter bounds in cycles, cut to the counter width on purpose
   localparam [31:0] filt_min_w = `SID_FILT_MIN_CYC;
   localparam [31:0] filt_max_w = `SID_FILT_MAX_CYC;

   assign mode       = ctrl[`SID_CTRL_MODE_MSB:`SID_CTRL_MODE_LSB];
   assign raw        = {enable_in, dir_in, step_in};
   // clamp below to the 50 ns floor and above to the 12.9 us ceiling
   assign filt_limit = (filt[9:0] < filt_min_w[9:0]) ? filt_min_w[9:0] :
                       (filt[9:0] > filt_max_w[9:0]) ? filt_max_w[9:0] :
                       filt[9:0];

   // glitch filter: a level is taken once stable for filt_limit cycles
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         filt_q    <= 3'h4;  // enable reads as high until proven low
         filt_prev <= 3'h4;
         for (i = 0; i < 3; i = i + 1) begin
            filt_cnt[i] <= 10'h000;
         end
      end else begin
         filt_prev <= filt_q;
         for (i = 0; i < 3; i = i + 1) begin
            // counter restarts when the level returns, so glitches never add up
            if (raw[i] == filt_q[i]) begin
               filt_cnt[i] <= 10'h000;
            end else if (filt_cnt[i] + 10'h001 >= filt_limit) begin
               filt_q[i]   <= raw[i];
               filt_cnt[i] <= 10'h000;
            end else begin
               filt_cnt[i] <= filt_cnt[i] + 10'h001;
            end
         end
      end
   end

   assign a_rise  = filt_q[0] & ~filt_prev[0];
   assign b_rise  = filt_q[1] & ~filt_prev[1];
   assign a_chg   = filt_q[0] ^ filt_prev[0];
   assign b_chg   = filt_q[1] ^ filt_prev[1];
   // direction sense inverted by software
   assign dir_eff = filt_q[1] ^ ctrl[`SID_CTRL_INV_BIT];
   assign res_ext = {23'h000000, lat_res};

   // decode the selected clock mode into one position update
   always @* begin
      next_position = position_out;
      next_lat_dir  = lat_dir;
      next_lat_res  = lat_res;
      case (mode)
         `SID_MODE_STEPDIR: begin
            if (a_rise) begin
               // latch at the edge; changes between edges wait here
               next_lat_dir = dir_eff;
               next_lat_res = ctrl[`SID_CTRL_RES_MSB:`SID_CTRL_RES_LSB];
               if (dir_eff) begin
                  next_position = position_out
                                  + {23'h000000, next_lat_res};
               end else begin
                  next_position = position_out
                                  - {23'h000000, next_lat_res};
               end
            end
         end
         `SID_MODE_QUAD: begin
            // a single-phase change is valid; both at once is dropped
            if (a_chg ^ b_chg) begin
               // new a^b, flipped when b moved, is high while a leads b
               if ((filt_q[0] ^ filt_q[1] ^ b_chg) ^ ctrl[`SID_CTRL_INV_BIT]) begin
                  next_position = position_out + res_ext;
               end else begin
                  next_position = position_out - res_ext;
               end
            end
            next_lat_res = ctrl[`SID_CTRL_RES_MSB:`SID_CTRL_RES_LSB];
         end
         `SID_MODE_UPDN: begin
            // simultaneous up and down edges cancel
            if (a_rise & ~b_rise) begin
               next_position = position_out + res_ext;
            end else if (b_rise & ~a_rise) begin
               next_position = position_out - res_ext;
            end
            next_lat_res = ctrl[`SID_CTRL_RES_MSB:`SID_CTRL_RES_LSB];
         end
         default: begin
            next_position = position_out;
         end
      endcase
   end

   // position and power stage; counting never waits on enable
   // position wraps at 32 bits; the generator reads it as two's complement
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         position_out <= 32'h0000_0000;
         lat_dir      <= 1'b0;
         lat_res      <= 9'h100;
         power_en_out <= 1'b0;
      end else begin
         position_out <= next_position;
         lat_dir      <= next_lat_dir;
         lat_res      <= next_lat_res;
         power_en_out <= filt_q[2];
      end
   end

   // byte-lane merge of the write data onto the addressed register
   always @* begin
      case (aw_addr)
         `SID_CTRL_ADDR: wr_merged = ctrl;
         `SID_FILT_ADDR: wr_merged = filt;
         `SID_CURR_ADDR: wr_merged = {16'h0000, hold_current_out, run_current_out};
         default:        wr_merged = 32'h0000_0000;
      endcase
      // lanes with a clear strobe keep the old byte
      for (j = 0; j < 4; j = j + 1) begin
         if (w_strb[j]) begin
            wr_merged[j*8 +: 8] = w_data[j*8 +: 8];
         end
      end
   end

   // axi4-lite write side: address and data taken in either order
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         s_axi_awready    <= 1'b1;
         s_axi_wready     <= 1'b1;
         s_axi_bvalid     <= 1'b0;
         s_axi_bresp      <= `SID_RESP_OKAY;
         aw_held          <= 1'b0;
         w_held           <= 1'b0;
         aw_addr          <= 4'h0;
         w_data           <= 32'h0000_0000;
         w_strb           <= 4'h0;
         ctrl             <= `SID_CTRL_RESET;
         filt             <= `SID_FILT_RESET;
         run_current_out  <= `SID_CURR_RUN_RESET;
         hold_current_out <= `SID_CURR_HLD_RESET;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr       <= s_axi_awaddr;
            aw_held       <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data       <= s_axi_wdata;
            w_strb       <= s_axi_wstrb;
            w_held       <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (aw_held && w_held && !s_axi_bvalid) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= `SID_RESP_OKAY;
            // unmapped offsets answer slverr and store nothing
            case (aw_addr)
               `SID_CTRL_ADDR: ctrl <= wr_merged & 32'h0001_ff07;
               `SID_FILT_ADDR: filt <= {22'h000000, wr_merged[9:0]};
               `SID_CURR_ADDR: begin
                  // current takes effect now, no step edge needed
                  run_current_out  <= wr_merged[7:0];
                  hold_current_out <= wr_merged[15:8];
               end
               `SID_POS_ADDR: s_axi_bresp <= `SID_RESP_OKAY;
               default: s_axi_bresp <= `SID_RESP_SLVERR;
            endcase
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // axi4-lite read side, one cycle from address to data
   // position read is a snapshot; a step in the same cycle shows on the next read
   always @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `SID_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= `SID_RESP_OKAY;
            case (s_axi_araddr)
               `SID_CTRL_ADDR: s_axi_rdata <= ctrl;
               `SID_FILT_ADDR: s_axi_rdata <= filt;
               `SID_CURR_ADDR: s_axi_rdata <= {13'h0000, filt_q, hold_current_out,
                                               run_current_out};
               `SID_POS_ADDR:  s_axi_rdata <= position_out;
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= `SID_RESP_SLVERR;
               end
            endcase
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule

// ===== tb/sid_chk.sv
/* port checker of the step input decoder.
   assumes a bind onto the decoder and full write strobes from the master. */
`timescale 1ns/1ps
module sid_chk (
   // clock, reset and pins
   input wire logic        clk_sys_in,
   input wire logic        nrst_in,
   input wire logic        enable_in,
   input wire logic        power_en_out,
   input wire logic [31:0] position_out,
   input wire logic [7:0]  run_current_out,
   input wire logic [7:0]  hold_current_out,
   // register bus
   input wire logic [3:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   logic [3:0]  aw_q;
   logic [31:0] w_q;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   // last write taken, so current outputs can be judged at the response
   always @(posedge clk_sys_in) begin
      if (s_axi_awvalid && s_axi_awready)
         aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
         w_q <= s_axi_wdata;
   end
   AST_PWR_ON: assert property ($rose(power_en_out) |->
      $past(enable_in) && $past(enable_in, 2)) else $error("power on without enable");
   AST_PWR_OFF: assert property ($fell(power_en_out) |->
      !$past(enable_in) && !$past(enable_in, 2)) else $error("power off while enabled");
   AST_RST_VAL: assert property ($rose(nrst_in) |-> position_out == 32'h0 &&
      run_current_out == 8'h19 && hold_current_out == 8'h05 && !power_en_out)
      else $error("bad state after reset");
   AST_STEP_SIZE: assert property ($changed(position_out) |->
      (position_out - $past(position_out) + 32'h1ff) <= 32'h3fe) else $error("step too large");
   AST_CURR_NOW: assert property ($rose(s_axi_bvalid) && aw_q == 4'h8 |->
      run_current_out == w_q[7:0] && hold_current_out == w_q[15:8])
      else $error("current not applied");
   AST_B_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##[1:2] s_axi_bvalid) else $error("write response late");
   AST_R_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read response late");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
      $stable(s_axi_rdata)) else $error("read response dropped");
   AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while answering");
   // main scenarios
   cover property ($fell(power_en_out));
   cover property ($rose(s_axi_bvalid) && aw_q == 4'h8);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind sid_step_input_decoder sid_chk u_chk (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
   .enable_in(enable_in), .power_en_out(power_en_out), .position_out(position_out),
   .run_current_out(run_current_out), .hold_current_out(hold_current_out),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready));

// ===== tb/sid_pulse_src.sv
/* motion controller model: drives step, direction and enable levels.
   assumes callers hold each level longer than the decoder filter. */
`timescale 1ns/1ps
module sid_pulse_src (
   // clock in, logic levels out
   input  wire logic clk_in,
   output logic      step_out,
   output logic      dir_out,
   output logic      en_out
);
   initial begin
      step_out = 1'b0;
      dir_out = 1'b0;
      en_out = 1'b1;
   end
   // levels change just after an edge and stand for h+1 cycles when calls follow back to back
   task automatic drive(input logic s, d, e, input int h);
      @(posedge clk_in);
      step_out <= s;
      dir_out <= d;
      en_out <= e;
      repeat (h) @(posedge clk_in);
   endtask
endmodule

// ===== tb/sid_step_input_decoder_tb.sv
/* bench of the step input decoder: axi4-lite master, pulse source, queued read checks.
   assumes a 40 MHz clock and the register layout of sid_map.vh. */
`timescale 1ns/1ps
`include "sid_map.vh"
module sid_step_input_decoder_tb;
   logic        clk = 0, nrst = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, en_on = 1;
   logic        awr, wr_rdy, bv, arr, rv, pen, step, dir, en;
   logic [3:0]  awaddr = 0, araddr = 0;
   logic [31:0] wdata = 0, rdata, pos, exp_pos = 0;
   logic [1:0]  bresp, rresp;
   logic [7:0]  runc, hldc, rc, hc;
   logic [7:0]  quad [8] = '{8'h2, 8'h3, 8'h1, 8'h0, 8'h1, 8'h3, 8'h2, 8'h0};
   logic [33:0] q [$];
   logic [33:0] e;
   int          fail_count = 0, n_tests = 0, n;
   sid_pulse_src src (.clk_in(clk), .step_out(step), .dir_out(dir), .en_out(en));
   sid_step_input_decoder DUT (.clk_sys_in(clk), .nrst_in(nrst), .step_in(step), .dir_in(dir),
      .enable_in(en), .power_en_out(pen), .position_out(pos), .run_current_out(runc),
      .hold_current_out(hldc), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
      .s_axi_awready(awr), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
      .s_axi_wready(wr_rdy), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry),
      .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rry));
   initial forever #12.5 clk = ~clk;
   task automatic chk(input string nm, input logic [31:0] x, s);
      n_tests++;
      if (s !== x) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic finish_test;
      if (fail_count == 0 && n_tests > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // write: both channels offered together, bready raised once both are taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = 0);
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awv <= 1;
      wv <= 1;
      forever begin
         @(posedge clk);
         if (awv && awr) awv <= 0;
         if (wv && wr_rdy) wv <= 0;
         if (bry && bv) break;
         else if (!awv && !wv) bry <= 1;
      end
      bry <= 0;
      chk("bresp", {30'h0, r}, {30'h0, bresp});
   endtask
   // read: rready comes a cycle late so the held answer is exercised
   task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [1:0] r = 0);
      q.push_back({r, x});
      @(posedge clk);
      araddr <= a;
      arv <= 1;
      forever begin
         @(posedge clk);
         if (arv && arr) arv <= 0;
         else if (rry && rv) break;
         else if (!arv) rry <= 1;
      end
      rry <= 0;
   endtask
   // oldest expected read against each answer
   always @(posedge clk)
      if (rv && rry) begin
         e = q.pop_front();
         chk("rdata", e[31:0], rdata);
         chk("rresp", {30'h0, e[33:32]}, {30'h0, rresp});
      end
   task automatic pulses(input int k, input logic d, input int h);
      src.drive(0, d, en_on, h);
      for (int i = 0; i < k; i++) begin
         src.drive(1, d, en_on, h);
         src.drive(0, d, en_on, h);
      end
   endtask
   initial begin
      repeat (20000) @(posedge clk);
      fail_count++;
      finish_test();
   end
   initial begin
      void'($urandom(44086));
      repeat (12) @(posedge clk);
      nrst <= 1;
      rd(`SID_CTRL_ADDR, `SID_CTRL_RESET);
      rd(`SID_FILT_ADDR, `SID_FILT_RESET);
      rd(4'h2, 32'h0, `SID_RESP_SLVERR);
      n = $urandom_range(1, 5);
      pulses(n, 1, 8);
      exp_pos = exp_pos + n * 256;
      rd(`SID_POS_ADDR, exp_pos);
      n = $urandom_range(1, 5);
      pulses(n, 0, 8);
      exp_pos = exp_pos - n * 256;
      rd(`SID_POS_ADDR, exp_pos);
      wr(`SID_CTRL_ADDR, 32'h0000_0500);
      rd(`SID_POS_ADDR, exp_pos);
      pulses(1, 1, 8);
      wr(`SID_CTRL_ADDR, 32'h0000_0504);
      pulses(2, 1, 8);
      en_on = 0;
      pulses(3, 1, 8);
      chk("power_en", 32'h0, {31'h0, pen});
      exp_pos = exp_pos + 5 - 25;
      rd(`SID_POS_ADDR, exp_pos);
      en_on = 1;
      src.drive(0, 1, 1, 8);
      chk("power_en", 32'h1, {31'h0, pen});
      wr(`SID_FILT_ADDR, 32'h0000_0014);
      wr(`SID_CTRL_ADDR, 32'h0000_0500);
      src.drive(1, 1, 1, 10);
      pulses(1, 1, 30);
      exp_pos = exp_pos + 5;
      rd(`SID_POS_ADDR, exp_pos);
      wr(`SID_FILT_ADDR, `SID_FILT_RESET);
      src.drive(0, 0, 1, 8);
      wr(`SID_CTRL_ADDR, 32'h0000_0501);
      for (int i = 0; i < 4; i++) src.drive(quad[i][1], quad[i][0], 1, 8);
      rd(`SID_POS_ADDR, exp_pos + 20);
      for (int i = 4; i < 8; i++) src.drive(quad[i][1], quad[i][0], 1, 8);
      rd(`SID_POS_ADDR, exp_pos);
      wr(`SID_CTRL_ADDR, 32'h0000_0502);
      pulses(3, 0, 8);
      src.drive(0, 1, 1, 8);
      src.drive(0, 0, 1, 8);
      exp_pos = exp_pos + 15 - 5;
      rd(`SID_POS_ADDR, exp_pos);
      rc = $urandom_range(1, 100);
      hc = $urandom_range(0, 100);
      wr(`SID_CURR_ADDR, {16'h0, hc, rc});
      rd(`SID_CURR_ADDR, {13'h0, 3'h4, hc, rc});
      wr(`SID_POS_ADDR, 32'h0000_1234);
      rd(`SID_POS_ADDR, exp_pos);
      wr(`SID_CTRL_ADDR, 32'h0000_0503);
      pulses(1, 1, 8);
      rd(`SID_POS_ADDR, exp_pos);
      wr(4'h2, 32'h0000_0000, `SID_RESP_SLVERR);
      rd(`SID_CTRL_ADDR, 32'h0000_0503);
      nrst <= 0;
      repeat (3) @(posedge clk);
      nrst <= 1;
      rd(`SID_CTRL_ADDR, `SID_CTRL_RESET);
      rd(`SID_POS_ADDR, 32'h0);
      pulses(1, 1, 8);
      rd(`SID_POS_ADDR, 32'h0000_0100);
      repeat (4) @(posedge clk);
      finish_test();
   end
endmodule
